// *** design/cps_core.sv ***
// Program-control core: accumulator side, return stack, interrupt gating.
// Assumes an AXI4-Lite master on aclk; one instruction per issued write.
// Functional notes
// - Carry set by add-with-carry, set/clear ops; immediate and memory add keep it
// - Rotate right copies accumulator bit 0 into carry
// - Wide register exchanges with temp (high nibble) and accumulator (low)
// - Pointer and accumulator form 7-bit in-page address for lookup/branch/call
// - Eight-entry return stack saves PC on call, lookup and interrupt entry
// - Pushing beyond eight levels wraps and corrupts, no indication
// - 3-bit depth pointer tracks level, readable into the accumulator
// - One-stage context register saves data pointer, carry, skip, acc, temp on irq
// - Skip flag decides skips and is preserved across interrupt service
// - PC advances by instruction length, or loads branch/call/return target
// - PC is page field plus 7-bit in-page field; 127 rolls to next page
// - Data pointer is group, file, digit; digit selects port bit
// - Program words are 10 bits, 128 per page, all readable by lookup
// - Upper bank lookups read pages 64-127, lower bank pages 0-63
// - Interrupt loads its page-1 vector into the PC
// - Page-2 call reaches page-2 start addresses from any page
// - Data memory is 128 four-bit words addressed by the data pointer
// - Interrupt taken only when global flag, enable and request all set
// - Global flag set by on op, cleared by off op and by any interrupt
// - Enable bit picks interrupt or skip-test use of each request
// - Request flags stick until taken or skipped on, even when disabled
// - Highest fixed priority pending source is serviced first
// - Taking an interrupt clears only that source's request flag
// - Irq-on takes effect after the following instruction completes
// - Interrupt starts 2 to 3 cycles after conditions met; 3 if multi-cycle
// - Enable 0 makes skip test valid; enable 1 makes it ineffective
`timescale 1ns/1ps
`default_nettype none
`include "cps_params.svh"
module cps_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] irq_event,
  input wire logic [9:0] rom_data,
  output logic [13:0] rom_addr,
  output logic [3:0] port_bit_sel,
  output logic [6:0] ram_addr
);
  // Write and read channel latches
  logic aw_hold_reg, aw_hold_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic w_hold_reg, w_hold_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic b_valid_reg, b_valid_next;
  logic [1:0] b_resp_reg, b_resp_next;
  logic r_valid_reg, r_valid_next;
  logic [31:0] r_data_reg, r_data_next;
  logic [1:0] r_resp_reg, r_resp_next;
  // Core state
  logic [3:0] acc_reg, acc_next;
  logic [3:0] temp_reg, temp_next;
  logic [7:0] wide_reg, wide_next;
  logic [2:0] ptr_reg, ptr_next;
  logic carry_flag_reg, carry_flag_next;
  logic skip_reg, skip_next;
  cps_pkg::cps_dptr_t dptr_reg, dptr_next;
  logic [13:0] pc_reg, pc_next;
  logic [13:0] stack_reg [0:7];
  logic [13:0] stack_next [0:7];
  logic [2:0] stack_depth_pointer_reg, stack_depth_pointer_next;
  cps_pkg::cps_ctx_t ctx_reg, ctx_next;
  logic global_irq_flag_reg, global_irq_flag_next;
  logic irq_on_pend_reg, irq_on_pend_next;
  logic [3:0] req_reg, req_next;
  logic [3:0] irq_enable_reg_a_reg, irq_enable_reg_a_next;
  logic [3:0] irq_enable_reg_b_reg, irq_enable_reg_b_next;
  logic bank_reg, bank_next;
  logic [9:0] rom_word_reg, rom_word_next;
  cps_pkg::cps_irq_state_t irq_state_reg, irq_state_next;
  logic [1:0] irq_cnt_reg, irq_cnt_next;
  logic [1:0] irq_src_reg, irq_src_next;
  logic [13:0] rom_addr_reg, rom_addr_next;
  logic lookup_pend_reg, lookup_pend_next;
  logic wr_fire;
  logic exec;
  cps_pkg::cps_op_t op;
  logic [3:0] operand;
  logic multi;
  logic [3:0] en_vec;
  logic [3:0] live;
  logic [4:0] sum;
  logic [2:0] push_idx;
  logic [13:0] seq_pc;
  logic [13:0] in_page_tgt;

  assign s_axi_awready = !aw_hold_reg && !b_valid_reg;
  assign s_axi_wready = !w_hold_reg && !b_valid_reg;
  assign s_axi_bvalid = b_valid_reg;
  assign s_axi_bresp = b_resp_reg;
  assign s_axi_arready = !r_valid_reg;
  assign s_axi_rvalid = r_valid_reg;
  assign s_axi_rdata = r_data_reg;
  assign s_axi_rresp = r_resp_reg;
  assign rom_addr = rom_addr_reg;
  assign port_bit_sel = dptr_reg.digit;
  assign ram_addr = {dptr_reg.file, dptr_reg.digit};

  assign wr_fire = aw_hold_reg && w_hold_reg && !b_valid_reg;
  assign exec = wr_fire && (aw_addr_reg == `CPS_ADDR_CTRL);
  assign op = cps_pkg::cps_op_t'(w_data_reg[4:0]);
  assign operand = w_data_reg[11:8];
  assign multi = w_data_reg[15];
  // Enable bits: ext=a[0], t1=a[2], t2=a[3], t3=b[0]
  assign en_vec = {irq_enable_reg_b_reg[0], irq_enable_reg_a_reg[3],
                   irq_enable_reg_a_reg[2], irq_enable_reg_a_reg[0]};
  assign live = req_reg & en_vec & {4{global_irq_flag_reg}};
  assign sum = {1'b0, acc_reg} + {1'b0, operand} + {4'h0, carry_flag_reg};
  assign push_idx = stack_depth_pointer_reg;
  assign seq_pc = pc_reg + {13'h0000, 1'b1} + {13'h0000, multi};
  assign in_page_tgt = {pc_reg[13:7], ptr_reg, acc_reg};

  always_comb
  begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next = w_hold_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    b_valid_next = b_valid_reg;
    b_resp_next = b_resp_reg;
    r_valid_next = r_valid_reg;
    r_data_next = r_data_reg;
    r_resp_next = r_resp_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      b_valid_next = 1'b1;
      b_resp_next = (aw_addr_reg == `CPS_ADDR_CTRL ||
                     aw_addr_reg == `CPS_ADDR_ENABLE) ?
                    `CPS_RESP_OKAY : `CPS_RESP_SLVERR;
    end
    if (b_valid_reg && s_axi_bready)
      b_valid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      r_valid_next = 1'b1;
      r_resp_next = `CPS_RESP_OKAY;
      unique case (s_axi_araddr)
        `CPS_ADDR_CTRL: r_data_next = 32'h0000_0000;
        `CPS_ADDR_ENABLE: r_data_next = {24'h00_0000, irq_enable_reg_b_reg,
                                         irq_enable_reg_a_reg};
        `CPS_ADDR_STATUS: r_data_next = {20'h0_0000, bank_reg,
          irq_on_pend_reg, global_irq_flag_reg, stack_depth_pointer_reg,
          skip_reg, carry_flag_reg, req_reg};
        `CPS_ADDR_PC: r_data_next = {18'h0_0000, pc_reg};
        `CPS_ADDR_REGS: r_data_next = {13'h0000, ptr_reg, wide_reg,
                                       temp_reg, acc_reg};
        `CPS_ADDR_ROMWORD: r_data_next = {22'h00_0000, rom_word_reg};
        `CPS_ADDR_DATAPTR: r_data_next = {23'h00_0000, dptr_reg};
        `CPS_ADDR_ROMADDR: r_data_next = {18'h0_0000, rom_addr_reg};
        default:
        begin
          r_data_next = 32'h0000_0000;
          r_resp_next = `CPS_RESP_SLVERR;
        end
      endcase
    end
    else if (r_valid_reg && s_axi_rready)
      r_valid_next = 1'b0;
  end

  always_comb
  begin
    acc_next = acc_reg;
    temp_next = temp_reg;
    wide_next = wide_reg;
    ptr_next = ptr_reg;
    carry_flag_next = carry_flag_reg;
    skip_next = skip_reg;
    dptr_next = dptr_reg;
    pc_next = pc_reg;
    for (int i = 0; i < `CPS_STACK_DEPTH; i++)
      stack_next[i] = stack_reg[i];
    stack_depth_pointer_next = stack_depth_pointer_reg;
    ctx_next = ctx_reg;
    global_irq_flag_next = global_irq_flag_reg;
    irq_on_pend_next = irq_on_pend_reg;
    req_next = req_reg;
    irq_enable_reg_a_next = irq_enable_reg_a_reg;
    irq_enable_reg_b_next = irq_enable_reg_b_reg;
    bank_next = bank_reg;
    rom_word_next = rom_word_reg;
    irq_state_next = irq_state_reg;
    irq_cnt_next = irq_cnt_reg;
    irq_src_next = irq_src_reg;
    rom_addr_next = pc_reg;
    lookup_pend_next = 1'b0;
    if (lookup_pend_reg)
    begin
      // Word at the lookup address answers one cycle later
      rom_word_next = rom_data;
      acc_next = rom_data[3:0];
      temp_next = rom_data[7:4];
    end
    if (wr_fire && aw_addr_reg == `CPS_ADDR_ENABLE && w_strb_reg[0])
    begin
      irq_enable_reg_a_next = w_data_reg[3:0];
      irq_enable_reg_b_next = w_data_reg[7:4];
    end
    unique case (irq_state_reg)
      cps_pkg::CPS_IDLE:
        if (live != 4'h0)
        begin
          irq_state_next = cps_pkg::CPS_WAIT;
          irq_cnt_next = (exec && multi) ? `CPS_IRQ_WAIT_LONG
                                         : `CPS_IRQ_WAIT_SHORT;
        end
      cps_pkg::CPS_WAIT:
        if (live == 4'h0)
          irq_state_next = cps_pkg::CPS_IDLE;
        else if (irq_cnt_reg == 2'd1)
          irq_state_next = cps_pkg::CPS_ENTER;
        else
          irq_cnt_next = irq_cnt_reg - 2'd1;
      cps_pkg::CPS_ENTER:
      begin
        irq_state_next = cps_pkg::CPS_IDLE;
        if (live[0]) irq_src_next = 2'd0;
        else if (live[1]) irq_src_next = 2'd1;
        else if (live[2]) irq_src_next = 2'd2;
        else irq_src_next = 2'd3;
      end
    endcase
    if (irq_state_reg == cps_pkg::CPS_ENTER && live != 4'h0)
    begin
      stack_next[push_idx] = pc_reg;
      stack_depth_pointer_next = stack_depth_pointer_reg + 3'd1;
      ctx_next = '{dptr_reg, carry_flag_reg, skip_reg, acc_reg,
                   temp_reg};
      global_irq_flag_next = 1'b0;
      irq_on_pend_next = 1'b0;
      if (live[0])
      begin
        req_next[0] = 1'b0;
        pc_next = `CPS_VEC_EXT;
      end
      else if (live[1])
      begin
        req_next[1] = 1'b0;
        pc_next = `CPS_VEC_T1;
      end
      else if (live[2])
      begin
        req_next[2] = 1'b0;
        pc_next = `CPS_VEC_T2;
      end
      else
      begin
        req_next[3] = 1'b0;
        pc_next = `CPS_VEC_T3;
      end
    end
    else if (exec)
    begin
      pc_next = seq_pc;
      if (irq_on_pend_reg)
      begin
        global_irq_flag_next = 1'b1;
        irq_on_pend_next = 1'b0;
      end
      unique case (op)
        cps_pkg::CPS_OP_ADD_CARRY:
        begin
          acc_next = sum[3:0];
          carry_flag_next = sum[4];
        end
        cps_pkg::CPS_OP_ADD_IMM, cps_pkg::CPS_OP_ADD_MEM:
          acc_next = acc_reg + operand;
        cps_pkg::CPS_OP_ROTATE_RIGHT:
        begin
          acc_next = {carry_flag_reg, acc_reg[3:1]};
          carry_flag_next = acc_reg[0];
        end
        cps_pkg::CPS_OP_SET_CARRY: carry_flag_next = 1'b1;
        cps_pkg::CPS_OP_CLEAR_CARRY: carry_flag_next = 1'b0;
        cps_pkg::CPS_OP_WIDE_FROM_PAIR:
          wide_next = {temp_reg, acc_reg};
        cps_pkg::CPS_OP_PAIR_FROM_WIDE:
        begin
          temp_next = wide_reg[7:4];
          acc_next = wide_reg[3:0];
        end
        cps_pkg::CPS_OP_TABLE_LOOKUP:
        begin
          // Page from target field bits 21:16, bank picks upper half
          rom_addr_next = {bank_reg, w_data_reg[21:16], ptr_reg, acc_reg};
          lookup_pend_next = 1'b1;
          stack_next[push_idx] = seq_pc;
          stack_depth_pointer_next = stack_depth_pointer_reg + 3'd1;
          stack_depth_pointer_next = stack_depth_pointer_reg; // Popped back
        end
        cps_pkg::CPS_OP_IND_BRANCH: pc_next = in_page_tgt;
        cps_pkg::CPS_OP_IND_CALL, cps_pkg::CPS_OP_CALL,
        cps_pkg::CPS_OP_PAGE2_CALL:
        begin
          stack_next[push_idx] = seq_pc;
          stack_depth_pointer_next = stack_depth_pointer_reg + 3'd1;
          if (op == cps_pkg::CPS_OP_IND_CALL)
            pc_next = in_page_tgt;
          else if (op == cps_pkg::CPS_OP_PAGE2_CALL)
            pc_next = `CPS_PAGE2_BASE | {7'h00, w_data_reg[22:16]};
          else
            pc_next = w_data_reg[29:16];
        end
        cps_pkg::CPS_OP_BRANCH: pc_next = w_data_reg[29:16];
        cps_pkg::CPS_OP_RETURN, cps_pkg::CPS_OP_RET_IRQ:
        begin
          stack_depth_pointer_next = stack_depth_pointer_reg - 3'd1;
          pc_next = stack_reg[stack_depth_pointer_reg - 3'd1];
          if (op == cps_pkg::CPS_OP_RET_IRQ)
          begin
            dptr_next = ctx_reg.dptr;
            carry_flag_next = ctx_reg.carry;
            skip_next = ctx_reg.skip;
            acc_next = ctx_reg.acc;
            temp_next = ctx_reg.temp;
          end
        end
        cps_pkg::CPS_OP_READ_DEPTH:
          acc_next = {1'b0, stack_depth_pointer_reg};
        cps_pkg::CPS_OP_IRQ_ON: irq_on_pend_next = 1'b1;
        cps_pkg::CPS_OP_IRQ_OFF:
        begin
          global_irq_flag_next = 1'b0;
          irq_on_pend_next = 1'b0;
        end
        cps_pkg::CPS_OP_UPPER_BANK: bank_next = 1'b1;
        cps_pkg::CPS_OP_LOWER_BANK: bank_next = 1'b0;
        cps_pkg::CPS_OP_SKIP_TEST:
        begin
          // Skip only valid while the source is disabled
          skip_next = req_reg[operand[1:0]] && !en_vec[operand[1:0]];
          if (skip_next)
          begin
            req_next[operand[1:0]] = 1'b0;
            pc_next = seq_pc + 14'h0001;
          end
        end
        cps_pkg::CPS_OP_LOAD_PTR:
        begin
          ptr_next = operand[2:0];
          dptr_next = w_data_reg[24:16];
        end
        cps_pkg::CPS_OP_LOAD_ACC: acc_next = operand;
        cps_pkg::CPS_OP_LOAD_TEMP: temp_next = operand;
        default: ;
      endcase
    end
    req_next = req_next | irq_event; // Set wins over clear
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      b_valid_reg <= 1'b0;
      b_resp_reg <= `CPS_RESP_OKAY;
      r_valid_reg <= 1'b0;
      r_data_reg <= 32'h0000_0000;
      r_resp_reg <= `CPS_RESP_OKAY;
      acc_reg <= 4'h0;
      temp_reg <= 4'h0;
      wide_reg <= 8'h00;
      ptr_reg <= 3'h0;
      carry_flag_reg <= 1'b0;
      skip_reg <= 1'b0;
      dptr_reg <= '0;
      pc_reg <= 14'h0000;
      for (int i = 0; i < `CPS_STACK_DEPTH; i++)
        stack_reg[i] <= 14'h0000;
      stack_depth_pointer_reg <= 3'h0;
      ctx_reg <= '0;
      global_irq_flag_reg <= 1'b0;
      irq_on_pend_reg <= 1'b0;
      req_reg <= 4'h0;
      irq_enable_reg_a_reg <= 4'h0;
      irq_enable_reg_b_reg <= 4'h0;
      bank_reg <= 1'b0;
      rom_word_reg <= 10'h000;
      irq_state_reg <= cps_pkg::CPS_IDLE;
      irq_cnt_reg <= 2'd0;
      irq_src_reg <= 2'd0;
      rom_addr_reg <= 14'h0000;
      lookup_pend_reg <= 1'b0;
    end
    else
    begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg <= w_hold_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      b_valid_reg <= b_valid_next;
      b_resp_reg <= b_resp_next;
      r_valid_reg <= r_valid_next;
      r_data_reg <= r_data_next;
      r_resp_reg <= r_resp_next;
      acc_reg <= acc_next;
      temp_reg <= temp_next;
      wide_reg <= wide_next;
      ptr_reg <= ptr_next;
      carry_flag_reg <= carry_flag_next;
      skip_reg <= skip_next;
      dptr_reg <= dptr_next;
      pc_reg <= pc_next;
      for (int i = 0; i < `CPS_STACK_DEPTH; i++)
        stack_reg[i] <= stack_next[i];
      stack_depth_pointer_reg <= stack_depth_pointer_next;
      ctx_reg <= ctx_next;
      global_irq_flag_reg <= global_irq_flag_next;
      irq_on_pend_reg <= irq_on_pend_next;
      req_reg <= req_next;
      irq_enable_reg_a_reg <= irq_enable_reg_a_next;
      irq_enable_reg_b_reg <= irq_enable_reg_b_next;
      bank_reg <= bank_next;
      rom_word_reg <= rom_word_next;
      irq_state_reg <= irq_state_next;
      irq_cnt_reg <= irq_cnt_next;
      irq_src_reg <= irq_src_next;
      rom_addr_reg <= rom_addr_next;
      lookup_pend_reg <= lookup_pend_next;
    end
  end

  // Checks
  a_rot_carry: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && op == cps_pkg::CPS_OP_ROTATE_RIGHT &&
    irq_state_reg != cps_pkg::CPS_ENTER |=> carry_flag_reg == $past(acc_reg[0]))
    else $error("rotate did not move bit 0 to carry");
  a_add_keeps_carry: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && op == cps_pkg::CPS_OP_ADD_IMM && irq_state_reg != cps_pkg::CPS_ENTER
    |=> $stable(carry_flag_reg))
    else $error("immediate add changed carry");
  a_irq_clears_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_state_reg == cps_pkg::CPS_ENTER && live != 4'h0 |=> !global_irq_flag_reg)
    else $error("global flag not cleared on entry");
  a_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    !global_irq_flag_reg |=> ctx_reg == $past(ctx_reg))
    else $error("interrupt taken without global flag");
  a_ext_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_state_reg == cps_pkg::CPS_ENTER && live[0] |=> pc_reg == `CPS_VEC_EXT)
    else $error("wrong external vector");
  a_push_depth: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && op == cps_pkg::CPS_OP_CALL && irq_state_reg != cps_pkg::CPS_ENTER
    |=> stack_depth_pointer_reg == $past(stack_depth_pointer_reg) + 3'd1)
    else $error("depth pointer did not advance");
  a_req_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_event[3] |=> req_reg[3])
    else $error("request flag lost");
  a_on_delayed: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && op == cps_pkg::CPS_OP_IRQ_ON && !global_irq_flag_reg &&
    !irq_on_pend_reg |=> !global_irq_flag_reg)
    else $error("irq-on took effect at once");
  c_irq_taken: cover property (@(posedge aclk) disable iff (!aresetn)
    irq_state_reg == cps_pkg::CPS_ENTER && live != 4'h0);
  c_call_return: cover property (@(posedge aclk) disable iff (!aresetn)
    exec && op == cps_pkg::CPS_OP_RETURN);
  c_lookup: cover property (@(posedge aclk) disable iff (!aresetn)
    exec && op == cps_pkg::CPS_OP_TABLE_LOOKUP && bank_reg);
endmodule
`default_nettype wire

// *** design/cps_params.svh ***
// Constants for the program-control core: widths, vectors, register addresses, responses, timing.
// Assumes inclusion by bare name from the package and the core.
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH
`define CPS_PC_W 14
`define CPS_STACK_DEPTH 8
`define CPS_VEC_EXT 14'h0080
`define CPS_VEC_T1 14'h0084
`define CPS_VEC_T2 14'h0086
`define CPS_VEC_T3 14'h0088
`define CPS_PAGE2_BASE 14'h0100
`define CPS_ADDR_CTRL 8'h00
`define CPS_ADDR_ENABLE 8'h04
`define CPS_ADDR_STATUS 8'h08
`define CPS_ADDR_PC 8'h0C
`define CPS_ADDR_REGS 8'h10
`define CPS_ADDR_ROMWORD 8'h14
`define CPS_ADDR_DATAPTR 8'h18
`define CPS_ADDR_ROMADDR 8'h1C
`define CPS_RESP_OKAY 2'b00
`define CPS_RESP_SLVERR 2'b10
`define CPS_IRQ_WAIT_SHORT 2'd2
`define CPS_IRQ_WAIT_LONG 2'd3
`endif

// *** design/cps_pkg.sv ***
// Types for the program-control core.
// Assumes cps_params.svh is on the include path.
`include "cps_params.svh"
package cps_pkg;
  typedef enum logic [4:0] {
    CPS_OP_NOP = 5'h00,
    CPS_OP_ADD_CARRY = 5'h01,
    CPS_OP_ADD_IMM = 5'h02,
    CPS_OP_ADD_MEM = 5'h03,
    CPS_OP_ROTATE_RIGHT = 5'h04,
    CPS_OP_SET_CARRY = 5'h05,
    CPS_OP_CLEAR_CARRY = 5'h06,
    CPS_OP_WIDE_FROM_PAIR = 5'h07,
    CPS_OP_PAIR_FROM_WIDE = 5'h08,
    CPS_OP_TABLE_LOOKUP = 5'h09,
    CPS_OP_IND_BRANCH = 5'h0A,
    CPS_OP_IND_CALL = 5'h0B,
    CPS_OP_CALL = 5'h0C,
    CPS_OP_PAGE2_CALL = 5'h0D,
    CPS_OP_BRANCH = 5'h0E,
    CPS_OP_RETURN = 5'h0F,
    CPS_OP_RET_IRQ = 5'h10,
    CPS_OP_READ_DEPTH = 5'h11,
    CPS_OP_IRQ_ON = 5'h12,
    CPS_OP_IRQ_OFF = 5'h13,
    CPS_OP_UPPER_BANK = 5'h14,
    CPS_OP_LOWER_BANK = 5'h15,
    CPS_OP_SKIP_TEST = 5'h16,
    CPS_OP_LOAD_PTR = 5'h17,
    CPS_OP_LOAD_ACC = 5'h18,
    CPS_OP_LOAD_TEMP = 5'h19
  } cps_op_t;
  typedef struct packed {
    logic [1:0] group;
    logic [2:0] file;
    logic [3:0] digit;
  } cps_dptr_t;
  typedef struct packed {
    cps_dptr_t dptr;
    logic carry;
    logic skip;
    logic [3:0] acc;
    logic [3:0] temp;
  } cps_ctx_t;
  typedef enum logic [1:0] {
    CPS_IDLE = 2'b00,
    CPS_WAIT = 2'b01,
    CPS_ENTER = 2'b10
  } cps_irq_state_t;
endpackage

// *** verification/cps_rom_model.sv ***
// Program ROM stand-in for the core.
// Assumes rom_addr comes registered from the core.
`timescale 1ns/1ps
`default_nettype none
module cps_rom_model (
  input wire logic [13:0] rom_addr,
  output logic [9:0] rom_data
);
  // Full word, answered at once
  assign rom_data = rom_addr[9:0] ^ {rom_addr[13:12], 8'hA5};
endmodule
`default_nettype wire

// *** verification/test_cps_core.sv ***
// Bench for the core: instructions issued over AXI4-Lite.
// Assumes cps_params.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "cps_params.svh"
module test_cps_core;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] irq_event, port_bit_sel;
  logic [9:0] rom_data;
  logic [13:0] rom_addr;
  logic [6:0] ram_addr;
  int err_total, comparisons;
  cps_core cps_core_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_event(irq_event),
    .rom_data(rom_data), .rom_addr(rom_addr), .port_bit_sel(port_bit_sel),
    .ram_addr(ram_addr));
  cps_rom_model cps_rom_model_i (.rom_addr(rom_addr), .rom_data(rom_data));
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One write (w=1) or one read, held until its response
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= {3{w}};
      {arvalid, rready} <= {2{!w}};
      for (n = 0; n < 40; n++)
      begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (arready) arvalid <= 1'b0;
        if ((w ? bvalid : rvalid) === 1'b1) break;
      end
      resp = w ? bresp : rresp;
      rd = rdata;
      {bready, rready} <= 2'b00;
      if (n == 40)
      begin
        err_total++;
        $display("Error response wait expected answer seen none");
        stop_test();
      end
    end
  endtask
  task automatic chk(input logic [33:0] v, e, input string s);
    begin
      comparisons++;
      if (v !== e)
      begin
        err_total++;
        $display("Error %s expected %h seen %h", s, e, v);
      end
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [33:0] m, e,
    input string s);
    begin
      bus(1'b0, a, 32'h0);
      chk({resp, rd} & m, e, s);
    end
  endtask
  task automatic ex(input cps_pkg::cps_op_t op, input logic [3:0] n,
    input logic [13:0] t);
    bus(1'b1, `CPS_ADDR_CTRL, {2'b00, t, 4'h0, n, 3'b000, op});
  endtask
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    {awaddr, araddr, wdata, irq_event} = '0;
    {err_total, comparisons} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`CPS_ADDR_STATUS, 34'h3_FFFF_FFFF, 34'h0, "status");
    $display("Test reset done");
    ex(cps_pkg::CPS_OP_SET_CARRY, 4'h0, 14'h0);
    ex(cps_pkg::CPS_OP_ADD_IMM, 4'hF, 14'h0);
    rchk(`CPS_ADDR_STATUS, 34'h10, 34'h10, "carry kept");
    ex(cps_pkg::CPS_OP_CLEAR_CARRY, 4'h0, 14'h0);
    rchk(`CPS_ADDR_STATUS, 34'h10, 34'h0, "carry clear");
    ex(cps_pkg::CPS_OP_LOAD_ACC, 4'h3, 14'h0);
    ex(cps_pkg::CPS_OP_ROTATE_RIGHT, 4'h0, 14'h0);
    rchk(`CPS_ADDR_STATUS, 34'h10, 34'h10, "rotate one");
    ex(cps_pkg::CPS_OP_LOAD_ACC, 4'hE, 14'h0);
    ex(cps_pkg::CPS_OP_ROTATE_RIGHT, 4'h0, 14'h0);
    rchk(`CPS_ADDR_STATUS, 34'h10, 34'h0, "rotate zero");
    $display("Test carry done");
    ex(cps_pkg::CPS_OP_BRANCH, 4'h0, 14'h007F);
    ex(cps_pkg::CPS_OP_NOP, 4'h0, 14'h0);
    rchk(`CPS_ADDR_PC, 34'h3FFF, 34'h80, "page roll");
    rchk(8'h20, 34'h3_FFFF_FFFF, 34'h2_0000_0000, "unmapped");
    $display("Test counter done");
    bus(1'b1, `CPS_ADDR_ENABLE, 32'h0000_001D);
    irq_event <= 4'b0110;
    @(posedge aclk);
    irq_event <= 4'b0000;
    rchk(`CPS_ADDR_STATUS, 34'hF, 34'h6, "requests");
    rchk(`CPS_ADDR_PC, 34'h3FFF, 34'h80, "no entry");
    ex(cps_pkg::CPS_OP_IRQ_ON, 4'h0, 14'h0);
    repeat (4) @(posedge aclk);
    rchk(`CPS_ADDR_PC, 34'h3FFF, 34'h81, "on delayed");
    ex(cps_pkg::CPS_OP_NOP, 4'h0, 14'h0);
    repeat (4) @(posedge aclk);
    rchk(`CPS_ADDR_PC, 34'h3FFF, 34'h84, "vector");
    rchk(`CPS_ADDR_STATUS, 34'h3CF, 34'h44, "entry");
    $display("Test interrupt done");
    ex(cps_pkg::CPS_OP_LOAD_PTR, 4'h5, 14'h00B6);
    ex(cps_pkg::CPS_OP_LOAD_ACC, 4'h9, 14'h0);
    ex(cps_pkg::CPS_OP_TABLE_LOOKUP, 4'h0, 14'h0003);
    rchk(`CPS_ADDR_ROMWORD, 34'h3FF, 34'h17C, "lookup word");
    rchk(`CPS_ADDR_REGS, 34'h7_00FF, 34'h5_007C, "lookup pair");
    chk({30'h0, port_bit_sel}, 34'h6, "port bit");
    chk({27'h0, ram_addr}, 34'h36, "ram address");
    ex(cps_pkg::CPS_OP_UPPER_BANK, 4'h0, 14'h0);
    ex(cps_pkg::CPS_OP_LOAD_ACC, 4'h9, 14'h0);
    ex(cps_pkg::CPS_OP_TABLE_LOOKUP, 4'h0, 14'h0003);
    rchk(`CPS_ADDR_ROMWORD, 34'h3FF, 34'h37C, "upper bank");
    $display("Test lookup done");
    ex(cps_pkg::CPS_OP_CALL, 4'h0, 14'h0200);
    ex(cps_pkg::CPS_OP_READ_DEPTH, 4'h0, 14'h0);
    ex(cps_pkg::CPS_OP_RETURN, 4'h0, 14'h0);
    rchk(`CPS_ADDR_REGS, 34'hF, 34'h2, "depth");
    rchk(`CPS_ADDR_PC, 34'h3FFF, 34'h8B, "return");
    ex(cps_pkg::CPS_OP_RET_IRQ, 4'h0, 14'h0);
    rchk(`CPS_ADDR_REGS, 34'hF, 34'hF, "restored acc");
    rchk(`CPS_ADDR_DATAPTR, 34'h1FF, 34'h0, "restored pointer");
    chk({20'h0, rom_addr}, 34'h82, "rom address");
    $display("Test stack done");
    irq_event <= 4'b1001;
    @(posedge aclk);
    irq_event <= 4'b0000;
    ex(cps_pkg::CPS_OP_IRQ_ON, 4'h0, 14'h0);
    ex(cps_pkg::CPS_OP_NOP, 4'h0, 14'h0);
    repeat (4) @(posedge aclk);
    rchk(`CPS_ADDR_PC, 34'h3FFF, 34'h80, "ext first");
    bus(1'b1, `CPS_ADDR_ENABLE, 32'h0000_000D);
    ex(cps_pkg::CPS_OP_SKIP_TEST, 4'h3, 14'h0);
    ex(cps_pkg::CPS_OP_SKIP_TEST, 4'h2, 14'h0);
    rchk(`CPS_ADDR_STATUS, 34'h2F, 34'h4, "skip flags");
    rchk(`CPS_ADDR_PC, 34'h3FFF, 34'h83, "skip pc");
    $display("Test skip done");
    stop_test();
  end
endmodule
`default_nettype wire
